// ===== design/bagr_regs.sv
// Behaviour
// - Any reset loads the pointer control register with 0x0004, so pointer zero starts in word mode.
// - Pointer control bits 15 to 3 are reserved and always read back as zero.
// - Pointer control bit 2 picks pointer zero access width: 1 is word mode, 0 is byte mode.
// - The general word is a 16-bit value that software reads and writes freely.
// - After reset the general word, swapped view and sign-extended view all read zero.
// - After reset the low-byte and high-byte views both read 0x00.
// - A low-byte write stores its 8 bits into general word bits 7 to 0.
// - A low-byte read returns general word bits 7 to 0.
// - A high-byte write stores its 8 bits into general word bits 15 to 8.
// - A high-byte read returns general word bits 15 to 8.
// - The swapped view is read-only and returns the general word with its bytes exchanged.
// - The sign-extended view is read-only and its upper 8 bits all equal general word bit 7.
// - The sign-extended view's lower 8 bits equal the general word low byte.
// - Every location is an index under module specifier 0x0e; other specifiers are not this block.
`timescale 1ns/1ps

module bagr_regs
  import bagr_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rd_data_o,
  output logic                   pointer_zero_width_select_o,
  output logic      [DATA_W-1:0] general_word_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] general_word;
    logic              width_select;
    logic [DATA_W-1:0] rd_data;
  } bagr_state_type;

  localparam bagr_state_type STATE_RESET = '{
    general_word: GENERAL_WORD_RESET,
    width_select: WIDTH_SELECT_RESET,
    rd_data:      READ_IDLE_VALUE
  };

  bagr_state_type state_reg;
  bagr_state_type state_next;
  bagr_loc_type   loc;
  logic [DATA_W-1:0] swapped_view;
  logic [DATA_W-1:0] sign_ext_view;
  logic [DATA_W-1:0] ptrctl_view;

  // ----------------------------------------------------------------
  // Address decode and derived views
  // ----------------------------------------------------------------
  // Strobes never overlap, so one decoder serves both reads and writes
  bagr_addr_decode u_decode (
    .addr_i (addr_i),
    .loc_o  (loc)
  );

  bagr_view_gen u_views (
    .word_i     (state_reg.general_word),
    .swapped_o  (swapped_view),
    .sign_ext_o (sign_ext_view)
  );

  always_comb
  begin
    ptrctl_view                   = '0;
    ptrctl_view[WIDTH_SELECT_POS] = state_reg.width_select;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next         = state_reg;
    state_next.rd_data = READ_IDLE_VALUE;

    if (wr_i)
    begin
      unique case (loc)
        BAGR_LOC_PTRCTL:
        begin
          // Reserved bits have no storage, so written values vanish
          state_next.width_select = wr_data_i[WIDTH_SELECT_POS];
        end
        BAGR_LOC_WORD:
        begin
          state_next.general_word = wr_data_i;
        end
        BAGR_LOC_LOW:
        begin
          state_next.general_word = bagr_merge_byte(state_reg.general_word,
                                                    wr_data_i[BYTE_W-1:0], LANE_LOW);
        end
        BAGR_LOC_HIGH:
        begin
          state_next.general_word = bagr_merge_byte(state_reg.general_word,
                                                    wr_data_i[BYTE_W-1:0], LANE_HIGH);
        end
        // Read-only views and foreign addresses ignore writes
        BAGR_LOC_SWAPPED,
        BAGR_LOC_SIGNEXT,
        BAGR_LOC_NONE:
        begin
          state_next.general_word = state_reg.general_word;
        end
      endcase
    end

    if (rd_i)
    begin
      unique case (loc)
        BAGR_LOC_PTRCTL:  state_next.rd_data = ptrctl_view;
        BAGR_LOC_WORD:    state_next.rd_data = state_reg.general_word;
        BAGR_LOC_LOW:     state_next.rd_data = {8'h00, state_reg.general_word[7:0]};
        BAGR_LOC_HIGH:    state_next.rd_data = {8'h00, state_reg.general_word[15:8]};
        BAGR_LOC_SWAPPED: state_next.rd_data = swapped_view;
        BAGR_LOC_SIGNEXT: state_next.rd_data = sign_ext_view;
        BAGR_LOC_NONE:    state_next.rd_data = READ_IDLE_VALUE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o                   = state_reg.rd_data;
  assign pointer_zero_width_select_o = state_reg.width_select;
  assign general_word_o              = state_reg.general_word;

endmodule : bagr_regs

// ===== design/bagr_pkg.sv
package bagr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned       DATA_W    = 16;
  localparam int unsigned       INDEX_W   = 5;
  localparam int unsigned       MODULE_W  = 5;
  localparam int unsigned       ADDR_W    = INDEX_W + MODULE_W;
  localparam int unsigned       BYTE_W    = 8;

  // ----------------------------------------------------------------
  // Locations: index plus module specifier
  // ----------------------------------------------------------------
  localparam logic [4:0]        MODULE_SPEC          = 5'h0e;
  localparam logic [4:0]        IDX_POINTER_CONTROL  = 5'h04;
  localparam logic [4:0]        IDX_GENERAL_WORD     = 5'h05;
  localparam logic [4:0]        IDX_GENERAL_LOW      = 5'h06;
  localparam logic [4:0]        IDX_GENERAL_SWAPPED  = 5'h08;
  localparam logic [4:0]        IDX_GENERAL_HIGH     = 5'h09;
  localparam logic [4:0]        IDX_GENERAL_SIGNEXT  = 5'h0a;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned       WIDTH_SELECT_POS     = 2;
  localparam logic              WIDTH_SELECT_RESET   = 1'b1;
  localparam logic [15:0]       GENERAL_WORD_RESET   = 16'h0000;
  localparam logic [15:0]       READ_IDLE_VALUE      = 16'h0000;
  localparam logic              LANE_LOW             = 1'b0;
  localparam logic              LANE_HIGH            = 1'b1;

  // ----------------------------------------------------------------
  // Decoded location, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    BAGR_LOC_NONE    = 7'b0000001,
    BAGR_LOC_PTRCTL  = 7'b0000010,
    BAGR_LOC_WORD    = 7'b0000100,
    BAGR_LOC_LOW     = 7'b0001000,
    BAGR_LOC_SWAPPED = 7'b0010000,
    BAGR_LOC_HIGH    = 7'b0100000,
    BAGR_LOC_SIGNEXT = 7'b1000000
  } bagr_loc_type;

  // Replace one byte lane of a word, keeping the other lane
  function automatic logic [15:0] bagr_merge_byte(
    input logic [15:0] word,
    input logic [7:0]  data,
    input logic        lane
  );
    logic [15:0] result;
    result = word;
    if (lane == LANE_HIGH)
    begin
      result[15:8] = data;
    end
    else
    begin
      result[7:0] = data;
    end
    return result;
  endfunction : bagr_merge_byte

endpackage : bagr_pkg

// ===== design/bagr_addr_decode.sv
`timescale 1ns/1ps

module bagr_addr_decode
  import bagr_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  output bagr_loc_type           loc_o
);

  logic [4:0] module_spec;
  logic [4:0] index;

  assign module_spec = addr_i[ADDR_W-1:INDEX_W];
  assign index       = addr_i[INDEX_W-1:0];

  // ----------------------------------------------------------------
  // Only module specifier 0x0e belongs to this block
  // ----------------------------------------------------------------
  always_comb
  begin
    loc_o = BAGR_LOC_NONE;
    if (module_spec == MODULE_SPEC)
    begin
      unique case (index)
        IDX_POINTER_CONTROL: loc_o = BAGR_LOC_PTRCTL;
        IDX_GENERAL_WORD:    loc_o = BAGR_LOC_WORD;
        IDX_GENERAL_LOW:     loc_o = BAGR_LOC_LOW;
        IDX_GENERAL_SWAPPED: loc_o = BAGR_LOC_SWAPPED;
        IDX_GENERAL_HIGH:    loc_o = BAGR_LOC_HIGH;
        IDX_GENERAL_SIGNEXT: loc_o = BAGR_LOC_SIGNEXT;
        default:             loc_o = BAGR_LOC_NONE;
      endcase
    end
  end

endmodule : bagr_addr_decode

// ===== design/bagr_view_gen.sv
`timescale 1ns/1ps

module bagr_view_gen
  import bagr_pkg::*;
(
  input  wire logic [DATA_W-1:0] word_i,
  output logic      [DATA_W-1:0] swapped_o,
  output logic      [DATA_W-1:0] sign_ext_o
);

  // ----------------------------------------------------------------
  // Byte exchange
  // ----------------------------------------------------------------
  assign swapped_o = {word_i[BYTE_W-1:0], word_i[DATA_W-1:BYTE_W]};

  // ----------------------------------------------------------------
  // Sign extension of the low byte
  // ----------------------------------------------------------------
  assign sign_ext_o[BYTE_W-1:0] = word_i[BYTE_W-1:0];

  genvar g;
  generate
    for (g = BYTE_W; g < DATA_W; g++)
    begin : gen_sign
      assign sign_ext_o[g] = word_i[BYTE_W-1];
    end
  endgenerate

endmodule : bagr_view_gen

// ===== tb/bagr_properties.sv
`timescale 1ns/1ps

module bagr_properties
  import bagr_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [DATA_W-1:0] rd_data_o,
  input  wire logic              pointer_zero_width_select_o,
  input  wire logic [DATA_W-1:0] general_word_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] gw;
  logic [4:0]  ix;
  logic        w;
  logic        r;
  assign gw = general_word_o;
  assign ix = addr_i[4:0];
  assign w  = wr_i && addr_i[9:5] == MODULE_SPEC;
  assign r  = rd_i && addr_i[9:5] == MODULE_SPEC;
  a_reset_values: assert property (disable iff (1'b0) rst_i |=> pointer_zero_width_select_o && gw == 16'h0000)
    else $error("reset values wrong");
  a_width_write: assert property (w && ix == IDX_POINTER_CONTROL |=> pointer_zero_width_select_o == $past(wr_data_i[2]))
    else $error("width select not written");
  a_ptr_read: assert property (r && ix == IDX_POINTER_CONTROL |=> rd_data_o == {13'h0000, pointer_zero_width_select_o, 2'h0})
    else $error("pointer control read wrong");
  a_word_write: assert property (w && ix == IDX_GENERAL_WORD |=> gw == $past(wr_data_i))
    else $error("word write lost");
  a_low_write: assert property (w && ix == IDX_GENERAL_LOW |=> gw == {$past(gw[15:8]), $past(wr_data_i[7:0])})
    else $error("low byte write wrong");
  a_high_write: assert property (w && ix == IDX_GENERAL_HIGH |=> gw == {$past(wr_data_i[7:0]), $past(gw[7:0])})
    else $error("high byte write wrong");
  a_byte_read: assert property (r && ix == IDX_GENERAL_HIGH ##1 1'b1 |-> rd_data_o == {8'h00, gw[15:8]})
    else $error("high byte read wrong");
  a_low_read: assert property (r && ix == IDX_GENERAL_LOW |=> rd_data_o == {8'h00, gw[7:0]})
    else $error("low byte read wrong");
  a_read_idle: assert property (!r |=> rd_data_o == 16'h0000)
    else $error("read data not idle");
  a_swap_read: assert property (r && ix == IDX_GENERAL_SWAPPED |=> rd_data_o == {gw[7:0], gw[15:8]})
    else $error("swapped read wrong");
  a_sext_read: assert property (r && ix == IDX_GENERAL_SIGNEXT |=> rd_data_o == {{8{gw[7]}}, gw[7:0]})
    else $error("sign extended read wrong");
  a_foreign_write: assert property (wr_i && addr_i[9:5] != MODULE_SPEC |=> $stable(gw) && $stable(pointer_zero_width_select_o))
    else $error("foreign write took effect");
  c_sext_negative: cover property (r && ix == IDX_GENERAL_SIGNEXT ##1 rd_data_o[15]);
  c_low_write: cover property (w && ix == IDX_GENERAL_LOW);
  c_byte_mode: cover property (w && ix == IDX_POINTER_CONTROL && !wr_data_i[2]);
endmodule : bagr_properties

bind bagr_regs bagr_properties bagr_properties_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .pointer_zero_width_select_o(pointer_zero_width_select_o), .general_word_o(general_word_o));

// ===== tb/bagr_core_model.sv
`timescale 1ns/1ps

module bagr_core_model
  import bagr_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [DATA_W-1:0] rd_data_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wr_data_o,
  output logic                   wr_o,
  output logic                   rd_o
);
  initial
  begin
    addr_o    = 10'h000;
    wr_data_o = 16'h0000;
    wr_o      = 1'b0;
    rd_o      = 1'b0;
  end
  // Idle bus shows inverted values so a stale address never looks valid
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_o    <= a;
    wr_data_o <= d;
    wr_o      <= 1'b1;
    @(posedge ref_clk_i);
    wr_o      <= 1'b0;
    addr_o    <= ~a;
    wr_data_o <= ~d;
  endtask : write
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rd_data_i;
    @(posedge ref_clk_i);
  endtask : read
endmodule : bagr_core_model

// ===== tb/byte_access_general_register_bench.sv
`timescale 1ns/1ps

module byte_access_general_register_bench
  import bagr_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [ADDR_W-1:0] addr, a;
  logic [DATA_W-1:0] wdata, rdata, gw_o, got, gw, d;
  logic              wr, rd, ws_o, ws;
  int                fails = 0, comparisons = 0, cycles = 0;
  logic [4:0]        idx [7] = '{IDX_POINTER_CONTROL, IDX_GENERAL_WORD, IDX_GENERAL_LOW, IDX_GENERAL_SWAPPED,
                                 IDX_GENERAL_HIGH, IDX_GENERAL_SIGNEXT, 5'h07};
  bagr_regs bagr_regs_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdata), .pointer_zero_width_select_o(ws_o), .general_word_o(gw_o));
  bagr_core_model bagr_core_model_inst (.ref_clk_i(ref_clk_i), .rd_data_i(rdata), .addr_o(addr),
    .wr_data_o(wdata), .wr_o(wr), .rd_o(rd));
  initial
  begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      finish_test();
    end
  end
  function automatic logic [15:0] exp_rd(logic [9:0] x, logic [15:0] g, logic s);
    if (x[9:5] !== MODULE_SPEC)
      return 16'h0000;
    case (x[4:0])
      IDX_POINTER_CONTROL: return {13'h0000, s, 2'h0};
      IDX_GENERAL_WORD:    return g;
      IDX_GENERAL_LOW:     return {8'h00, g[7:0]};
      IDX_GENERAL_SWAPPED: return {g[7:0], g[15:8]};
      IDX_GENERAL_HIGH:    return {8'h00, g[15:8]};
      IDX_GENERAL_SIGNEXT: return {{8{g[7]}}, g[7:0]};
      default:             return 16'h0000;
    endcase
  endfunction : exp_rd
  task automatic check(logic [15:0] g, logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : check
  task automatic do_wr(logic [9:0] x, logic [15:0] v);
    bagr_core_model_inst.write(x, v);
    if (x[9:5] === MODULE_SPEC)
      case (x[4:0])
        IDX_POINTER_CONTROL: ws = v[2];
        IDX_GENERAL_WORD:    gw = v;
        IDX_GENERAL_LOW:     gw[7:0] = v[7:0];
        IDX_GENERAL_HIGH:    gw[15:8] = v[7:0];
        default:             ;
      endcase
    #1;
    check(gw_o, gw);
    check({15'h0000, ws_o}, {15'h0000, ws});
  endtask : do_wr
  task automatic do_rd(logic [9:0] x);
    bagr_core_model_inst.read(x, got);
    check(got, exp_rd(x, gw, ws));
  endtask : do_rd
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    gw = 16'h0000;
    ws = 1'b1;
    for (int i = 0; i < 7; i++)
      do_rd({MODULE_SPEC, idx[i]});
  endtask : do_reset
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  initial
  begin
    void'($urandom(32360));
    do_reset();
    do_wr({MODULE_SPEC, IDX_GENERAL_WORD}, 16'h1280);
    for (int i = 0; i < 7; i++)
      do_rd({MODULE_SPEC, idx[i]});
    do_wr({MODULE_SPEC, IDX_GENERAL_SWAPPED}, 16'hffff);
    do_wr({MODULE_SPEC, IDX_POINTER_CONTROL}, 16'hfffb);
    do_rd({MODULE_SPEC, IDX_POINTER_CONTROL});
    for (int i = 0; i < 300; i++)
    begin
      a = {($urandom_range(0, 7) == 0) ? 5'h0d : MODULE_SPEC, idx[$urandom_range(0, 6)]};
      d = 16'($urandom());
      if ($urandom_range(0, 1) == 1)
        do_wr(a, d);
      else
        do_rd(a);
    end
    do_reset();
    finish_test();
  end
endmodule : byte_access_general_register_bench
